// ### core/pls_core.v
// Digital core of a PLL tuning synthesiser: band select, prescaler,
// programmable and reference dividers, twin phase detector, lock logic.
// Assumes a 25 MHz clk_sys, APB on the same clock, and all pins
// (oscillator inputs, serial link) asynchronous to clk_sys.
//
// Local design decisions: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "pls_defs.vh"

module pls_core #(
  parameter PH_WIN = 16'h0008
) (
  // Clock and reset
  input wire clk_sys,
  input wire rstn,
  // Oscillator pins
  input wire upper_band_osc_input,
  input wire lower_band_osc_input,
  input wire ref_osc_in,
  // Serial link pins
  input wire serial_shift_clock,
  input wire serial_data,
  input wire serial_word_enable,
  // APB slave
  input wire [7:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Phase detector and analog control
  output reg pd_up_r,
  output reg pd_dn_r,
  output reg sample_r,
  output reg [15:0] phase_hold_r,
  output reg dig_pd_en_r,
  output reg [3:0] gain_r,
  output reg prescaler_on_r,
  output reg test_out_r
);

  // ==========================================================
  // Input synchronisers
  localparam NIN = 6;
  wire [NIN-1:0] pin_raw;
  reg [NIN-1:0] s1_r;
  reg [NIN-1:0] s2_r;
  reg [NIN-1:0] s3_r;
  wire [NIN-1:0] rise;
  assign pin_raw = {serial_word_enable, serial_data, serial_shift_clock,
                    ref_osc_in, lower_band_osc_input, upper_band_osc_input};
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi = gi + 1) begin : g_sync
      always @(posedge clk_sys) begin
        if (!rstn) begin
          s1_r[gi] <= 1'b0;
          s2_r[gi] <= 1'b0;
          s3_r[gi] <= 1'b0;
        end else begin
          s1_r[gi] <= pin_raw[gi];
          s2_r[gi] <= s1_r[gi];
          s3_r[gi] <= s2_r[gi];
        end
      end
      assign rise[gi] = s2_r[gi] & ~s3_r[gi];
    end
  endgenerate
  wire up_edge = rise[0];
  wire lo_edge = rise[1];
  wire ref_edge = rise[2];
  wire sck_rise = rise[3];
  wire sdat = s2_r[4];
  wire sen = s2_r[5];
  wire sen_fall = ~s2_r[5] & s3_r[5];
  // ==========================================================
  // Control latch and decoded fields
  reg [14:0] ctrl_r;
  reg [14:0] div_pend_r;
  reg [14:0] div_n_r;
  reg div_new_r;
  wire band_up = ctrl_r[`PLS_C_BAND];
  wire feat_on = ctrl_r[`PLS_C_FEAT];
  wire [1:0] pdm = {ctrl_r[`PLS_C_PHASE_DET_MODE_BIT1], ctrl_r[`PLS_C_PDM0]};
  wire [3:0] tsel = ctrl_r[`PLS_C_TEST_HI:`PLS_C_TEST_LO];
  wire sync_ld = feat_on & ctrl_r[`PLS_C_SYNC];
  // ==========================================================
  // Serial receiver
  reg [16:0] sh_r;
  reg [4:0] bitcnt_r;
  reg [15:0] word_r;
  reg word_ok_r;
  wire xfer = ~sen & sck_rise & word_ok_r;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      sh_r <= 17'h00000;
      bitcnt_r <= 5'h00;
      word_r <= 16'h0000;
      word_ok_r <= 1'b0;
    end else begin
      if (sen) begin
        if (sck_rise) begin
          sh_r <= {sh_r[15:0], sdat};
          if (bitcnt_r != 5'h1F) begin
            bitcnt_r <= bitcnt_r + 5'h01;
          end
        end
      end else begin
        bitcnt_r <= 5'h00;
      end
      if (sen_fall && bitcnt_r == `PLS_WORD_LEN && !sh_r[`PLS_START_BIT]) begin
        word_r <= sh_r[15:0];
        word_ok_r <= 1'b1;
      end else if (xfer) begin
        word_ok_r <= 1'b0;
      end
    end
  end
  // ==========================================================
  // APB slave
  wire apb_acc = psel & penable & ~pready;
  // Write lands at the edge where the master sees pready high
  wire apb_wr = psel & penable & pready & pwrite;
  wire [3:0] lock_cnt_w;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= apb_acc;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
      if (apb_acc) begin
        case (paddr)
          `PLS_OFS_FREQ: prdata <= {17'h00000, div_n_r};
          `PLS_OFS_CTRL: prdata <= {17'h00000, ctrl_r};
          `PLS_OFS_STAT: prdata <= {24'h000000, lock_cnt_w, word_ok_r,
                                    div_new_r, prescaler_on_r, dig_pd_en_r};
          `PLS_OFS_PHASE: prdata <= {16'h0000, phase_hold_r};
          default: pslverr <= 1'b1;
        endcase
      end
    end
  end
  // ==========================================================
  // Latches fed from serial link or APB
  wire ser_freq = xfer & ~word_r[`PLS_LATCH_BIT];
  wire apb_freq = apb_wr & (paddr == `PLS_OFS_FREQ);
  wire samp_pulse;
  wire apply = div_new_r & (~sync_ld | samp_pulse);
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_r <= `PLS_RST_CTRL;
      div_pend_r <= `PLS_RST_DIV;
      div_n_r <= `PLS_RST_DIV;
      div_new_r <= 1'b0;
    end else begin
      if (xfer && word_r[`PLS_LATCH_BIT]) begin
        ctrl_r <= word_r[14:0];
      end else if (apb_wr && paddr == `PLS_OFS_CTRL) begin
        ctrl_r <= pwdata[14:0];
      end
      if (ser_freq || apb_freq) begin
        div_pend_r <= ser_freq ? word_r[14:0] : pwdata[14:0];
        div_new_r <= 1'b1;
      end else if (apply) begin
        div_new_r <= 1'b0;
      end
      if (apply) begin
        div_n_r <= div_pend_r;
      end
    end
  end
  // ==========================================================
  // Band select, prescaler, programmable divider
  reg [3:0] pre_cnt_r;
  reg [14:0] pcnt_r;
  reg div_pulse_r;
  wire pre_in = band_up ? up_edge : 1'b0;
  wire pre_tc = pre_in && pre_cnt_r == `PLS_PRESCALE - 4'h1;
  wire lo_pulse = band_up ? pre_tc : lo_edge;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      pre_cnt_r <= 4'h0;
      prescaler_on_r <= 1'b0;
      pcnt_r <= 15'h0000;
      div_pulse_r <= 1'b0;
    end else begin
      prescaler_on_r <= band_up;
      if (!band_up) begin
        pre_cnt_r <= 4'h0;
      end else if (pre_in) begin
        pre_cnt_r <= pre_tc ? 4'h0 : pre_cnt_r + 4'h1;
      end
      div_pulse_r <= 1'b0;
      if (lo_pulse) begin
        if (pcnt_r == 15'h0000) begin
          pcnt_r <= div_n_r - 15'h0001;
          div_pulse_r <= 1'b1;
        end else begin
          pcnt_r <= pcnt_r - 15'h0001;
        end
      end
    end
  end
  // ==========================================================
  // Reference divider and sampling divider
  reg [6:0] rcnt_r;
  reg ref_pulse_r;
  reg ref_sq_r;
  reg [4:0] scnt_r;
  wire [6:0] rdiv = ctrl_r[`PLS_C_REF_DIVISOR_SELECT] ? `PLS_REF_DIV_HI : `PLS_REF_DIV_LO;
  assign samp_pulse = ref_pulse_r && scnt_r == `PLS_SAMPLE_DIV;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      rcnt_r <= 7'h00;
      ref_pulse_r <= 1'b0;
      ref_sq_r <= 1'b0;
      scnt_r <= 5'h00;
    end else begin
      ref_pulse_r <= 1'b0;
      if (ref_edge) begin
        if (rcnt_r >= rdiv - 7'h01) begin
          rcnt_r <= 7'h00;
          ref_pulse_r <= 1'b1;
          ref_sq_r <= ~ref_sq_r;
        end else begin
          rcnt_r <= rcnt_r + 7'h01;
        end
      end
      if (ref_pulse_r) begin
        scnt_r <= scnt_r + 5'h01;
      end
    end
  end
  // ==========================================================
  // Phase frequency detector and sampled detector
  reg up_st_r;
  reg dn_st_r;
  reg [15:0] width_r;
  reg [15:0] last_w_r;
  wire both = (up_st_r | ref_pulse_r) & (dn_st_r | div_pulse_r);
  wire [15:0] mag = last_w_r[15] ? (16'h0000 - last_w_r) : last_w_r;
  wire out_rng = mag > PH_WIN;
  always @(posedge clk_sys) begin
    if (!rstn) begin
      up_st_r <= 1'b0;
      dn_st_r <= 1'b0;
      width_r <= 16'h0000;
      last_w_r <= 16'h0000;
      pd_up_r <= 1'b0;
      pd_dn_r <= 1'b0;
      sample_r <= 1'b0;
      phase_hold_r <= 16'h0000;
    end else begin
      if (both) begin
        up_st_r <= 1'b0;
        dn_st_r <= 1'b0;
        last_w_r <= width_r;
        width_r <= 16'h0000;
      end else begin
        up_st_r <= up_st_r | ref_pulse_r;
        dn_st_r <= dn_st_r | div_pulse_r;
        if (up_st_r) begin
          width_r <= width_r + 16'h0001;
        end else if (dn_st_r) begin
          width_r <= width_r - 16'h0001;
        end
      end
      pd_up_r <= up_st_r & dig_pd_en_r;
      pd_dn_r <= dn_st_r & dig_pd_en_r;
      sample_r <= samp_pulse;
      if (samp_pulse) begin
        phase_hold_r <= last_w_r;
      end
    end
  end
  // ==========================================================
  // In-lock detector
  reg [1:0] lock_cnt_r;
  assign lock_cnt_w = {2'b00, lock_cnt_r};
  always @(posedge clk_sys) begin
    if (!rstn) begin
      lock_cnt_r <= 2'h0;
      dig_pd_en_r <= 1'b1;
    end else begin
      if (feat_on && pdm == `PLS_PDM_OFF) begin
        dig_pd_en_r <= 1'b0;
        lock_cnt_r <= 2'h0;
      end else if (feat_on && pdm == `PLS_PDM_ON) begin
        dig_pd_en_r <= 1'b1;
        lock_cnt_r <= 2'h0;
      end else if (samp_pulse) begin
        if (out_rng) begin
          dig_pd_en_r <= 1'b1;
          lock_cnt_r <= 2'h0;
        end else if (lock_cnt_r == `PLS_LOCK_COUNT - 2'h1) begin
          dig_pd_en_r <= 1'b0;
          lock_cnt_r <= `PLS_LOCK_COUNT;
        end else if (lock_cnt_r != `PLS_LOCK_COUNT) begin
          lock_cnt_r <= lock_cnt_r + 2'h1;
        end
      end
    end
  end
  // ==========================================================
  // Alignment output and gain
  always @(posedge clk_sys) begin
    if (!rstn) begin
      test_out_r <= 1'b0;
      gain_r <= 4'h0;
    end else begin
      gain_r <= ctrl_r[`PLS_C_GAIN_HI:`PLS_C_GAIN_LO];
      if (!feat_on) begin
        test_out_r <= 1'b0;
      end else begin
        case (tsel)
          `PLS_TST_REF: test_out_r <= ref_sq_r;
          `PLS_TST_DIV: test_out_r <= div_pulse_r;
          `PLS_TST_LOCK: test_out_r <= ~dig_pd_en_r;
          default: test_out_r <= 1'b0;
        endcase
      end
    end
  end
endmodule

// ### pkg/pls_defs.vh
// Constants of the tuning synthesiser digital core: APB map, control word
// fields, reset values and divider counts. Definitions only.
`ifndef PLS_DEFS_VH
`define PLS_DEFS_VH

// APB register byte offsets
`define PLS_OFS_FREQ 8'h00
`define PLS_OFS_CTRL 8'h04
`define PLS_OFS_STAT 8'h08
`define PLS_OFS_PHASE 8'h0C

// Serial word layout, 17 bits, first bit sent is bit 16
`define PLS_WORD_LEN 5'h11
`define PLS_START_BIT 16
`define PLS_LATCH_BIT 15

// Control word fields
`define PLS_C_BAND 0
`define PLS_C_REF_DIVISOR_SELECT 1
`define PLS_C_GAIN_LO 2
`define PLS_C_GAIN_HI 5
`define PLS_C_FEAT 6
`define PLS_C_SYNC 7
`define PLS_C_PDM0 8
`define PLS_C_PHASE_DET_MODE_BIT1 9
`define PLS_C_BRM 10
`define PLS_C_TEST_LO 11
`define PLS_C_TEST_HI 14

// Reset values
`define PLS_RST_DIV 15'h0200
`define PLS_RST_CTRL 15'h0000

// Divider counts
`define PLS_REF_DIV_LO 7'h7D
`define PLS_REF_DIV_HI 7'h64
`define PLS_PRESCALE 4'hA
`define PLS_SAMPLE_DIV 5'h1F
`define PLS_LOCK_COUNT 2'h3
`define PLS_DIV_MIN 15'h0200

// Phase detector modes with feature bits in use
`define PLS_PDM_AUTO 2'h0
`define PLS_PDM_OFF 2'h1
`define PLS_PDM_ON 2'h2

// Test routing codes
`define PLS_TST_REF 4'h1
`define PLS_TST_DIV 4'h2
`define PLS_TST_LOCK 4'h4

`endif

// ### tb/pls_core_properties.sv
// Checker for pls_core: APB answers and detector gating.
// Assumes a bind into pls_core; sees its ports only.
`timescale 1ns/10ps
module pls_core_props (
  // Clock and reset
  input logic clk_sys,
  input logic rstn,
  // APB
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic [31:0] prdata,
  input logic pready,
  input logic pslverr,
  // Detectors
  input logic pd_up_r,
  input logic pd_dn_r,
  input logic sample_r,
  input logic dig_pd_en_r
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  property p_pd_gated;
    !dig_pd_en_r && !$past(dig_pd_en_r) |-> !pd_up_r && !pd_dn_r;
  endproperty
  a_pd_gated: assert property (p_pd_gated) else $error("pd on while off");
  property p_pd_quiet;
    $fell(dig_pd_en_r) |-> ##2 (!pd_up_r && !pd_dn_r) [*3];
  endproperty
  a_pd_quiet: assert property (p_pd_quiet) else $error("pd not quiet");
  property p_sample_gap;
    sample_r |=> !sample_r [*8];
  endproperty
  a_sample_gap: assert property (p_sample_gap) else $error("sample too soon");
  property p_ready_one;
    pready |=> !pready;
  endproperty
  a_ready_one: assert property (p_ready_one) else $error("pready too long");
  property p_ready_cause;
    pready |-> $past(psel) && $past(penable) && !$past(pready);
  endproperty
  a_ready_cause: assert property (p_ready_cause) else $error("pready unasked");
  property p_err_ready;
    pslverr |-> pready;
  endproperty
  a_err_ready: assert property (p_err_ready) else $error("pslverr alone");
  property p_err_zero;
    pslverr |-> prdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("data on error");
  property p_err_addr;
    pready && $past(paddr) > 8'h0C |-> pslverr;
  endproperty
  a_err_addr: assert property (p_err_addr) else $error("unmapped accepted");
endmodule
bind pls_core pls_core_props u_props (
  .clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .pd_up_r(pd_up_r),
  .pd_dn_r(pd_dn_r), .sample_r(sample_r), .dig_pd_en_r(dig_pd_en_r)
);

// ### tb/pls_mcu_model.sv
// Controller side of the three-wire serial link.
// Assumes the bench calls send; the link clock idles low between frames.
`timescale 1ns/10ps
module pls_mcu (
  // Serial link
  output logic serial_shift_clock = 1'b0,
  output logic serial_data = 1'b1,
  output logic serial_word_enable = 1'b0
);
  // Sends nbit clocks of w from w[16]; 320 ns link period
  task automatic send(input logic [16:0] w, input int nbit);
    #10;
    serial_word_enable = 1'b1;
    for (int i = 0; i < nbit; i++) begin
      serial_data = w[16 - i];
      #160 serial_shift_clock = 1'b1;
      #160 serial_shift_clock = 1'b0;
    end
    // Released line must not look like held data
    serial_data = ~serial_data;
    #160 serial_word_enable = 1'b0;
    #160 serial_shift_clock = 1'b1;
    #160 serial_shift_clock = 1'b0;
    #160;
  endtask
endmodule

// ### tb/pls_core_bench.sv
// Bench for pls_core: APB master, free oscillators, serial partner.
// Assumes pls_core_props is bound in and pls_mcu drives the link.
`timescale 1ns/10ps
`include "pls_defs.vh"
module pls_core_bench;
  logic clk_sys = 1'b0, rstn = 1'b0;
  logic lo_osc = 1'b0, hi_osc = 1'b0, ref_osc = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic re;
  wire [31:0] prdata;
  wire pready, pslverr, pd_up_r, pd_dn_r, sample_r, dig_pd_en_r, prescaler_on_r, test_out_r;
  wire [15:0] phase_hold_r;
  wire [3:0] gain_r;
  wire sclk, sdat, sen;
  int err_total = 0;
  int tests_run = 0;
  int cnt [3] = '{0, 0, 0};
  // Oscillators are whole multiples of clk_sys so edge counts stay exact
  always #20 clk_sys = ~clk_sys;
  always #80 lo_osc = ~lo_osc;
  always #80 hi_osc = ~hi_osc;
  always #80 ref_osc = ~ref_osc;
  always @(posedge lo_osc) cnt[0]++;
  always @(posedge hi_osc) cnt[1]++;
  always @(posedge ref_osc) cnt[2]++;
  pls_core u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .upper_band_osc_input(hi_osc),
    .lower_band_osc_input(lo_osc), .ref_osc_in(ref_osc), .serial_shift_clock(sclk),
    .serial_data(sdat), .serial_word_enable(sen), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .pd_up_r(pd_up_r), .pd_dn_r(pd_dn_r),
    .sample_r(sample_r), .phase_hold_r(phase_hold_r), .dig_pd_en_r(dig_pd_en_r),
    .gain_r(gain_r), .prescaler_on_r(prescaler_on_r), .test_out_r(test_out_r)
  );
  pls_mcu u_mcu (.serial_shift_clock(sclk), .serial_data(sdat), .serial_word_enable(sen));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("comparisons %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    // Waits however long pready takes; only the watchdog ends a stuck access
    do begin
      @(posedge clk_sys);
    end while (pready !== 1'b1);
    rd = prdata;
    re = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(a, 1'b0, 32'h0);
    chk(rd, exp);
  endtask
  // Rising edge of the divider test pulse, or of sample_r for w of 2
  task automatic seek(input int w);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      while ((w == 2 ? sample_r : test_out_r) !== (k == 1) && n < 60000) begin
        @(posedge clk_sys);
        n++;
      end
    end
  endtask
  task automatic measure(input int w, input int exp);
    int c;
    seek(w);
    c = cnt[w];
    seek(w);
    chk(cnt[w] - c, exp);
  endtask
  initial begin
    repeat (10) @(posedge clk_sys);
    rstn <= 1'b1;
    rdchk(`PLS_OFS_FREQ, 32'h0000_0200);
    rdchk(`PLS_OFS_CTRL, 32'h0000_0000);
    chk(dig_pd_en_r, 1'b1);
    apb(8'h10, 1'b0, 32'h0);
    chk(re, 1'b1);
    chk(rd, 32'h0);
    $display("reset test done");
    u_mcu.send({2'b00, 15'h0258}, 17);
    rdchk(`PLS_OFS_FREQ, 32'h0000_0258);
    u_mcu.send({2'b10, 15'h02BC}, 17);
    u_mcu.send({2'b00, 15'h02BC}, 16);
    rdchk(`PLS_OFS_FREQ, 32'h0000_0258);
    $display("serial test done");
    u_mcu.send({2'b01, 15'h1140}, 17);
    repeat (5) @(posedge clk_sys);
    chk(dig_pd_en_r, 1'b0);
    u_mcu.send({2'b01, 15'h1240}, 17);
    rdchk(`PLS_OFS_CTRL, 32'h0000_1240);
    chk(dig_pd_en_r, 1'b1);
    measure(0, 600);
    $display("lower band test done");
    apb(`PLS_OFS_CTRL, 1'b1, 32'h0000_1143);
    apb(`PLS_OFS_FREQ, 1'b1, 32'h0000_0200);
    chk(prescaler_on_r, 1'b1);
    rdchk(`PLS_OFS_FREQ, 32'h0000_0200);
    fork
      measure(1, 5120);
      measure(2, 3200);
    join
    $display("upper band test done");
    seek(2);
    apb(`PLS_OFS_CTRL, 1'b1, 32'h0000_11C3);
    apb(`PLS_OFS_FREQ, 1'b1, 32'h0000_02BC);
    rdchk(`PLS_OFS_FREQ, 32'h0000_0200);
    apb(`PLS_OFS_STAT, 1'b0, 32'h0);
    chk(rd[3:0], 4'h6);
    seek(2);
    repeat (3) @(posedge clk_sys);
    rdchk(`PLS_OFS_FREQ, 32'h0000_02BC);
    $display("sync load test done");
    apb(`PLS_OFS_CTRL, 1'b1, 32'h0000_2157);
    repeat (2) @(posedge clk_sys);
    chk(test_out_r, 1'b1);
    chk(gain_r, 4'h5);
    $display("alignment test done");
    conclude;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    err_total++;
    $display("CHECK FAILED at %0t: watchdog expired", $time);
    conclude;
  end
endmodule
